// [rtl/psc_loader.sv]
`timescale 1ns/1ns
module psc_loader
  import psc_pkg::*;
#(
  parameter int NCH   = NUM_CH,
  parameter int NST   = NUM_STAT,
  parameter int NREGS = NUM_REGS
)(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 power_down_pin,
  input  wire logic                 config_source_select_pin,
  input  wire logic [5:0]           cfg_pin,
  input  wire logic [1:0]           cfg_tri1,
  input  wire logic [1:0]           cfg_tri2,
  input  wire logic [1:0]           cfg_tri3,
  input  wire logic [2:0]           offset_select_a,
  output logic      [2:0]           ee_page,
  output logic      [6:0]           ee_addr,
  output logic                      ee_rd_en,
  input  wire logic [7:0]           ee_data,
  input  wire logic                 host_wr,
  input  wire logic                 host_rd,
  input  wire logic [6:0]           host_addr,
  input  wire logic [7:0]           host_wdata,
  output logic                      host_ready,
  output logic      [7:0]           host_rdata,
  output logic                      host_rvalid,
  output logic      [1:0]           i2c_addr_lsb,
  output logic                      offset_select_a_enable,
  output logic      [2:0]           offset_select_a_offset,
  output logic                      cfg_invalid,
  output logic                      hard_mode,
  output logic                      load_done,
  output logic      [7:0]           page_id,
  output logic                      div_sync,
  output logic                      pll_power_down,
  output logic                      pll_doubler,
  output logic      [11:0]          pll_int,
  output logic      [1:0]           pri_in_type,
  output logic      [1:0]           sec_in_type,
  output logic      [1:0]           in_mux_mode,
  output logic      [2:0]           pri_ref_div,
  input  wire logic                 pll_lock,
  input  wire logic                 ref_present,
  input  wire logic [NCH-1:0]       ch_clk_pll,
  input  wire logic [NCH-1:0]       ch_clk_ref,
  output logic      [NCH-1:0]       ch_out_p,
  output logic      [NCH-1:0]       ch_out_n,
  output logic      [NCH-1:0]       ch_drive_en,
  output logic      [NCH-1:0][7:0]  ch_div,
  output logic      [NST-1:0]       stat_clk_mode,
  output logic      [NST-1:0]       stat_slew,
  output logic      [NST-1:0][7:0]  stat_div
);

  localparam logic [6:0] LAST_REG = 7'(NREGS - 1);

  typedef struct packed {
    psc_fsm_type                st;
    logic [6:0]                 idx;
    logic                       hard;
    logic [5:0]                 pins;
    logic [2:0]                 page;
    logic                       dflt;
    logic                       inval;
    logic [1:0]                 addr_lsb;
    logic                       marg_en;
    logic [2:0]                 marg_off;
    logic                       sync;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic [NREGS-1:0][7:0]      regs;
  } psc_core_type;

  psc_core_type r, n;
  logic [7:0]   rom_data;
  logic [7:0]   load_byte;
  logic [4:0]   soft_sel;

  // {default, invalid, page} from the two three-level page pins
  function automatic logic [4:0] psc_soft_page(input logic [1:0] p3,
                                               input logic [1:0] p2);
    logic [4:0] s;
    s = {2'b00, 3'h0};
    case ({p3, p2})
      {TRI_GND, TRI_GND}: s = {2'b00, 3'h0};
      {TRI_GND, TRI_MID}: s = {2'b00, 3'h1};
      {TRI_GND, TRI_VDD}: s = {2'b00, 3'h2};
      {TRI_MID, TRI_GND}: s = {2'b00, 3'h3};
      {TRI_MID, TRI_MID}: s = {2'b10, 3'h0};
      {TRI_MID, TRI_VDD}: s = {2'b00, 3'h4};
      {TRI_VDD, TRI_GND}: s = {2'b00, 3'h5};
      default:            s = {2'b11, 3'h0};
    endcase
    return s;
  endfunction : psc_soft_page

  function automatic logic [1:0] psc_addr_bits(input logic [1:0] t);
    logic [1:0] a;
    a = ADDR_GND;
    if (t == TRI_MID) begin
      a = ADDR_MID;
    end else if (t == TRI_VDD) begin
      a = ADDR_VDD;
    end
    return a;
  endfunction : psc_addr_bits

  psc_rom_page u_rom (
    .page (r.pins),
    .addr (r.idx),
    .data (rom_data)
  );

  assign soft_sel = psc_soft_page(cfg_tri3, cfg_tri2);

  // Source of the byte being loaded
  always_comb begin
    if (r.hard) begin
      load_byte = rom_data;
    end else if (!r.dflt) begin
      load_byte = ee_data;
    end else begin
      load_byte = psc_default_byte(r.idx);
    end
  end

  always_comb begin
    n        = r;
    n.sync   = 1'b0;
    n.rvalid = 1'b0;
    case (r.st)
      ST_HOLD: begin
        n.st = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        // Straps captured once per power-up
        n.hard     = config_source_select_pin;
        n.pins     = cfg_pin;
        n.page     = soft_sel[2:0];
        n.dflt     = soft_sel[4];
        n.inval    = soft_sel[3];
        n.marg_en  = cfg_pin[4];
        n.marg_off = offset_select_a;
        if (config_source_select_pin) begin
          n.addr_lsb = ADDR_HARD;
          n.marg_en  = 1'b0;
          n.marg_off = 3'h0;
        end else begin
          n.addr_lsb = psc_addr_bits(cfg_tri1);
        end
        n.idx = 7'h00;
        n.st  = ST_LOAD;
      end
      ST_LOAD: begin
        // One byte per cycle into the register file
        n.regs[r.idx] = load_byte;
        if (r.idx == LAST_REG) begin
          n.st = ST_SYNC;
        end else begin
          n.idx = r.idx + 7'h01;
        end
      end
      ST_SYNC: begin
        n.sync = r.hard;
        n.st   = ST_RUN;
      end
      ST_RUN: begin
        n.sync = ~r.hard & ~cfg_pin[0];
        if (host_wr && host_addr <= LAST_REG) begin
          n.regs[host_addr] = host_wdata;
        end
        if (host_rd) begin
          n.rvalid = 1'b1;
          n.rdata  = (host_addr <= LAST_REG) ? r.regs[host_addr] : 8'h00;
        end
      end
      default: begin
        n.st = ST_HOLD;
      end
    endcase
    // Power-down restarts sampling and loading on release
    if (power_down_pin) begin
      n.st   = ST_HOLD;
      n.sync = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign host_ready    = (r.st == ST_RUN);
  assign host_rdata    = r.rdata;
  assign host_rvalid   = r.rvalid;
  assign ee_page       = r.page;
  assign ee_addr       = r.idx;
  assign ee_rd_en      = (r.st == ST_LOAD) & ~r.hard & ~r.dflt;
  assign i2c_addr_lsb  = r.addr_lsb;
  assign offset_select_a_enable = r.marg_en;
  assign offset_select_a_offset = r.marg_off;
  assign cfg_invalid   = r.inval & ~r.hard;
  assign hard_mode     = r.hard;
  assign load_done     = (r.st == ST_RUN);
  assign div_sync      = r.sync;

  // Decoded configuration fields
  assign page_id        = r.regs[REG_PAGE_ID];
  assign pll_power_down = r.regs[REG_PLL_CTRL][PLL_PDN_BIT];
  assign pll_doubler    = r.regs[REG_PLL_CTRL][PLL_DBL_BIT];
  assign pll_int        = {r.regs[REG_INT_HI][3:0],
                           r.regs[REG_INT_LO]};
  assign pri_in_type    = r.regs[REG_IN_CTRL][1:0];
  assign sec_in_type    = r.regs[REG_IN_CTRL][3:2];
  assign in_mux_mode    = r.regs[REG_IN_CTRL][5:4];
  assign pri_ref_div    = r.regs[REG_REF_DIV][2:0];

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      localparam int BASE = int'(REG_CH_BASE) + c * CH_STRIDE;
      logic [7:0] mux_b;
      logic [7:0] fmt_b;
      logic [7:0] mute_b;
      assign mux_b     = r.regs[BASE + int'(CH_MUX)];
      assign fmt_b     = r.regs[BASE + int'(CH_FMT)];
      assign mute_b    = r.regs[BASE + int'(CH_MUTE)];
      assign ch_div[c] = r.regs[BASE + int'(CH_DIV)];
      psc_out_mute u_mute (
        .clk         (clk),
        .resetn      (resetn),
        .out_en      (r.st == ST_RUN),
        .src_clk     (mux_b[0] ? ch_clk_pll[c] : ch_clk_ref[c]),
        .src_is_pll  (mux_b[0]),
        .pll_lock    (pll_lock),
        .ref_present (ref_present),
        .fmt         (fmt_b[1:0]),
        .mute_en     (mute_b[0]),
        .mute_lvl    (mute_b[2:1]),
        .out_p       (ch_out_p[c]),
        .out_n       (ch_out_n[c]),
        .drive_en    (ch_drive_en[c])
      );
    end
    for (genvar s = 0; s < NST; s++) begin : g_st
      localparam int SB = int'(REG_ST_BASE) + s * ST_STRIDE;
      assign stat_clk_mode[s] = r.regs[SB][ST_CLK_BIT];
      assign stat_slew[s]     = r.regs[SB][ST_SLEW_BIT];
      assign stat_div[s]      = r.regs[SB + 1];
    end
  endgenerate

endmodule : psc_loader

// [common/psc_pkg.sv]
package psc_pkg;

  localparam int          NUM_REGS     = 124;
  localparam int          NUM_CH       = 8;
  localparam int          NUM_STAT     = 2;
  localparam int          ROM_PAGES    = 64;
  localparam int          EE_PAGES     = 6;

  // Register offsets
  localparam logic [6:0]  REG_PAGE_ID  = 7'h00;
  localparam logic [6:0]  REG_PLL_CTRL = 7'h01;
  localparam logic [6:0]  REG_INT_HI   = 7'h02;
  localparam logic [6:0]  REG_INT_LO   = 7'h03;
  localparam logic [6:0]  REG_IN_CTRL  = 7'h04;
  localparam logic [6:0]  REG_REF_DIV  = 7'h05;
  localparam logic [6:0]  REG_CH_BASE  = 7'h08;
  localparam logic [6:0]  REG_CH_END   = 7'h28;
  localparam logic [6:0]  REG_ST_BASE  = 7'h28;
  localparam logic [6:0]  REG_ST_END   = 7'h2c;
  localparam int          CH_STRIDE    = 4;
  localparam int          ST_STRIDE    = 2;

  // Field positions inside a channel group, and bit positions in the PLL control and status registers
  localparam logic [1:0]  CH_MUX       = 2'h0;
  localparam logic [1:0]  CH_DIV       = 2'h1;
  localparam logic [1:0]  CH_FMT       = 2'h2;
  localparam logic [1:0]  CH_MUTE      = 2'h3;
  localparam int          PLL_PDN_BIT  = 0;
  localparam int          PLL_DBL_BIT  = 1;
  localparam int          ST_CLK_BIT   = 0;
  localparam int          ST_SLEW_BIT  = 1;

  // Default values loaded on the default page and in the fixed pages
  localparam logic [7:0]  DEF_PLL_CTRL = 8'h00;
  localparam logic [7:0]  DEF_INT_LO   = 8'h64;
  localparam logic [7:0]  DEF_IN_CTRL  = 8'h00;
  localparam logic [7:0]  DEF_REF_DIV  = 8'h00;
  localparam logic [7:0]  DEF_CH_MUX   = 8'h01;
  localparam logic [7:0]  DEF_CH_DIV   = 8'h03;
  localparam logic [7:0]  DEF_CH_FMT   = 8'h01;
  localparam logic        DEF_MUTE_EN  = 1'h1;
  localparam logic [1:0]  DEF_MUTE_LVL = 2'h3;

  // Three-level pin codes
  localparam logic [1:0]  TRI_GND      = 2'h0;
  localparam logic [1:0]  TRI_MID      = 2'h1;
  localparam logic [1:0]  TRI_VDD      = 2'h2;

  localparam logic [1:0]  ADDR_HARD    = 2'h0;
  localparam logic [1:0]  ADDR_GND     = 2'h0;
  localparam logic [1:0]  ADDR_MID     = 2'h1;
  localparam logic [1:0]  ADDR_VDD     = 2'h3;

  localparam logic [1:0]  FMT_OFF      = 2'h0;
  localparam logic [1:0]  FMT_DIFF     = 2'h1;
  localparam logic [1:0]  FMT_CMOS     = 2'h2;

  typedef enum logic [2:0] {
    ST_HOLD   = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_LOAD   = 3'b010,
    ST_SYNC   = 3'b011,
    ST_RUN    = 3'b100
  } psc_fsm_type;

  function automatic logic [7:0] psc_default_byte(input logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == REG_PLL_CTRL) begin
      d = DEF_PLL_CTRL;
    end else if (a == REG_INT_LO) begin
      d = DEF_INT_LO;
    end else if (a == REG_IN_CTRL) begin
      d = DEF_IN_CTRL;
    end else if (a == REG_REF_DIV) begin
      d = DEF_REF_DIV;
    end else if (a >= REG_CH_BASE && a < REG_CH_END) begin
      case (a[1:0])
        CH_MUX:  d = DEF_CH_MUX;
        CH_DIV:  d = DEF_CH_DIV;
        CH_FMT:  d = DEF_CH_FMT;
        default: d = {5'h00, DEF_MUTE_LVL, DEF_MUTE_EN};
      endcase
    end
    return d;
  endfunction : psc_default_byte

endpackage : psc_pkg

// [rtl/psc_rom_page.sv]
`timescale 1ns/1ns
module psc_rom_page
  import psc_pkg::*;
(
  input  wire logic [5:0] page,
  input  wire logic [6:0] addr,
  output logic      [7:0] data
);

  // Fixed pages: defaults with page-dependent identifier, PLL integer low byte and channel dividers
  always_comb begin
    data = psc_default_byte(addr);
    if (addr == REG_PAGE_ID) begin
      data = {2'h0, page};
    end else if (addr == REG_INT_LO) begin
      data = DEF_INT_LO + {2'h0, page};
    end else if (addr >= REG_CH_BASE && addr < REG_CH_END &&
                 addr[1:0] == CH_DIV) begin
      data = {2'h0, page};
    end
  end

endmodule : psc_rom_page

// [rtl/psc_out_mute.sv]
`timescale 1ns/1ns
module psc_out_mute
  import psc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       out_en,
  input  wire logic       src_clk,
  input  wire logic       src_is_pll,
  input  wire logic       pll_lock,
  input  wire logic       ref_present,
  input  wire logic [1:0] fmt,
  input  wire logic       mute_en,
  input  wire logic [1:0] mute_lvl,
  output logic            out_p,
  output logic            out_n,
  output logic            drive_en
);

  typedef struct packed {
    logic       muted;
    logic       en;
    logic [1:0] fmt;
    logic [1:0] lvl;
  } psc_mute_type;

  psc_mute_type r, n;

  always_comb begin
    n       = r;
    n.muted = mute_en & ~(src_is_pll ? pll_lock : ref_present);
    n.en    = out_en & (fmt != FMT_OFF);
    n.fmt   = fmt;
    n.lvl   = mute_lvl;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    drive_en = r.en;
    out_p    = 1'b0;
    out_n    = 1'b0;
    if (r.en && r.fmt == FMT_DIFF) begin
      if (r.muted) begin
        out_p = r.lvl[1];
        out_n = ~r.lvl[0];
      end else begin
        out_p = src_clk;
        out_n = ~src_clk;
      end
    end else if (r.en && !r.muted) begin
      out_p = src_clk;
      out_n = src_clk;
    end
    // Muted single-ended output stays low
  end

endmodule : psc_out_mute

// [verification/psc_eeprom_model.sv]
`timescale 1ns/1ns
module psc_eeprom_model (
  input  wire logic       clk,
  input  wire logic [2:0] ee_page,
  input  wire logic [6:0] ee_addr,
  input  wire logic       ee_rd_en,
  output logic      [7:0] ee_data
);
  logic [7:0] junk_r = 8'h5a;
  // Bus shows churn when not read, never the last byte
  always @(posedge clk) begin
    junk_r <= junk_r + 8'h37;
  end
  // Byte 0 is a page identifier unique to each page
  assign ee_data = ee_rd_en ? ({ee_page, ee_addr[4:0]} ^ 8'h2b) : junk_r;
endmodule : psc_eeprom_model

// [verification/psc_loader_checker.sv]
`timescale 1ns/1ns
module psc_loader_checker
  import psc_pkg::*;
#(
  parameter int NCH = NUM_CH
)(
  input wire logic           clk,
  input wire logic           resetn,
  input wire logic           power_down_pin,
  input wire logic [5:0]     cfg_pin,
  input wire logic [6:0]     ee_addr,
  input wire logic           ee_rd_en,
  input wire logic           host_rd,
  input wire logic [6:0]     host_addr,
  input wire logic           host_ready,
  input wire logic [7:0]     host_rdata,
  input wire logic           host_rvalid,
  input wire logic [1:0]     i2c_addr_lsb,
  input wire logic           offset_select_a_enable,
  input wire logic [2:0]     offset_select_a_offset,
  input wire logic           cfg_invalid,
  input wire logic           hard_mode,
  input wire logic           load_done,
  input wire logic           div_sync,
  input wire logic [NCH-1:0] ch_drive_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] idle_r;
  // Cycles spent outside run, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_r <= 8'h00;
    end else if (load_done) begin
      idle_r <= 8'h00;
    end else if (idle_r != 8'hff) begin
      idle_r <= idle_r + 8'h01;
    end
  end
  rd_answer_a: assert property (
    host_rd && host_ready |=> host_rvalid) else $error("read lost");
  rvalid_cause_a: assert property (
    host_rvalid |-> $past(host_rd && host_ready)) else $error("stray rvalid");
  unmapped_read_a: assert property (
    host_rvalid && $past(host_addr) > 7'd123 |-> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  idle_drive_a: assert property (
    !load_done |=> ch_drive_en == '0) else $error("outputs on in init");
  hard_addr_a: assert property (
    hard_mode && load_done |-> i2c_addr_lsb == ADDR_HARD)
    else $error("hard address bits");
  hard_sync_a: assert property (
    hard_mode && $rose(load_done) |-> div_sync ##1 !div_sync)
    else $error("hard sync pulse");
  soft_sync_a: assert property (
    !hard_mode && load_done && $past(load_done)
    |-> div_sync == !$past(cfg_pin[0])) else $error("soft sync level");
  strap_hold_a: assert property (
    load_done && $past(load_done) |-> $stable(i2c_addr_lsb)
    && $stable(offset_select_a_offset) && $stable(cfg_invalid) && $stable(hard_mode))
    else $error("straps changed in run");
  load_len_a: assert property (
    $rose(load_done) |-> idle_r >= 8'd125) else $error("load too short");
  eeprom_range_a: assert property (
    ee_rd_en |-> !load_done && ee_addr < 7'd124) else $error("bad eeprom read");
  pdn_stop_a: assert property (
    power_down_pin |=> !load_done && !host_ready) else $error("run in pdn");
  hard_offset_select_a_a: assert property (
    hard_mode && load_done |-> !offset_select_a_enable && offset_select_a_offset == 3'h0)
    else $error("hard margining on");
endmodule : psc_loader_checker

bind psc_loader psc_loader_checker #(.NCH(NCH)) chk_i (.*);

// [verification/test_psc_loader.sv]
`timescale 1ns/1ns
module test_psc_loader;
  import psc_pkg::*;
  localparam int NCH = NUM_CH;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic power_down_pin = 1'b0;
  logic config_source_select_pin = 1'b1;
  logic [5:0] cfg_pin = 6'h00;
  logic [1:0] cfg_tri1 = 2'h0, cfg_tri2 = 2'h0, cfg_tri3 = 2'h0;
  logic [2:0] offset_select_a = 3'h0;
  logic host_wr = 1'b0, host_rd = 1'b0;
  logic [6:0] host_addr = 7'h00;
  logic [7:0] host_wdata = 8'h00;
  logic pll_lock = 1'b1, ref_present = 1'b1;
  logic [NCH-1:0] ch_clk_pll = '0, ch_clk_ref = '0;
  logic [2:0] ee_page, offset_select_a_offset, pri_ref_div;
  logic [6:0] ee_addr;
  logic [7:0] ee_data, host_rdata, page_id, rd, p;
  logic ee_rd_en, host_ready, host_rvalid, offset_select_a_enable, cfg_invalid;
  logic hard_mode, load_done, div_sync, pll_power_down, pll_doubler;
  logic [1:0] i2c_addr_lsb, pri_in_type, sec_in_type, in_mux_mode;
  logic [11:0] pll_int;
  logic [NCH-1:0] ch_out_p, ch_out_n, ch_drive_en;
  logic [NCH-1:0][7:0] ch_div;
  logic [NUM_STAT-1:0] stat_clk_mode, stat_slew;
  logic [NUM_STAT-1:0][7:0] stat_div;
  int fails = 0, total_checks = 0, cycles = 0, t2, t3;
  logic [2:0] ep;

  always #5 clk = ~clk;
  psc_loader dut (.*);
  psc_eeprom_model eeprom (.*);

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [11:0] e, logic [11:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    host_wr = w;
    host_rd = !w;
    host_addr = a;
    host_wdata = d;
    step(1);
    rd = host_rdata;
    if (!w) chk("rvalid", 1, host_rvalid);
    host_wr = 1'b0;
    host_rd = 1'b0;
    // Idle edge so the next call never re-raises a strobe in this step
    step(1);
  endtask : acc

  task automatic restart();
    int i;
    power_down_pin = 1'b1;
    step(2);
    power_down_pin = 1'b0;
    step(3);
    // Write while loading must be dropped
    host_wr = 1'b1;
    host_addr = REG_PAGE_ID;
    host_wdata = 8'hee;
    step(1);
    host_wr = 1'b0;
    for (i = 0; i < 400 && load_done !== 1'b1; i++) step(1);
    chk("load_done", 1, load_done);
  endtask : restart

  function automatic int exp_page(input int a, input int b);
    case (a * 3 + b)
      0, 1, 2, 3: return a * 3 + b;
      4: return 6;
      5: return 4;
      6: return 5;
      default: return 7;
    endcase
  endfunction : exp_page

  function automatic logic [7:0] ee_exp(input logic [2:0] pg, logic [6:0] a);
    if (pg > 3'h5) return (a == 7'h00) ? 8'h00 : DEF_CH_DIV;
    return {pg, a[4:0]} ^ 8'h2b;
  endfunction : ee_exp

  task automatic hard_case(input logic [5:0] pg);
    config_source_select_pin = 1'b1;
    cfg_pin = pg;
    restart();
    chk("page_id", {2'h0, pg}, page_id);
    chk("pll_int", {4'h0, 8'h64 + {2'h0, pg}}, pll_int);
    chk("ch_div", {2'h0, pg}, ch_div[NCH-1]);
    chk("addr_lsb", ADDR_HARD, i2c_addr_lsb);
    chk("div_sync", 1, div_sync);
    cfg_pin = ~pg;
    step(3);
    chk("latched", {2'h0, pg}, page_id);
  endtask : hard_case

  initial begin
    void'($urandom(32'ha557));
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    hard_case(6'h00);
    hard_case(6'h3f);
    hard_case(6'($urandom));
    p = 8'($urandom);
    acc(1'b1, REG_REF_DIV, p);
    acc(1'b0, REG_REF_DIV, 8'h00);
    chk("rdata", p, rd);
    chk("ref_div", p[2:0], pri_ref_div);
    acc(1'b1, 7'h7c, 8'h5a);
    acc(1'b0, 7'h7c, 8'h00);
    chk("unmapped", 0, rd);
    pll_lock = 1'b0;
    step(3);
    chk("mute_diff", 2'b10, {ch_out_p[1], ch_out_n[1]});
    chk("drive_en", 1, ch_drive_en[1]);
    acc(1'b1, 7'h0f, 8'h01);
    step(2);
    chk("mute_lvl", 2'b01, {ch_out_p[1], ch_out_n[1]});
    acc(1'b1, 7'h0e, {6'h00, FMT_CMOS});
    acc(1'b1, 7'h13, 8'h00);
    step(2);
    chk("mute_cmos", 2'b00, {ch_out_p[1], ch_out_n[1]});
    chk("unmuted", 2'b01, {ch_out_p[2], ch_out_n[2]});
    pll_lock = 1'b1;
    config_source_select_pin = 1'b0;
    for (t3 = 0; t3 < 3; t3++) begin
      for (t2 = 0; t2 < 3; t2++) begin
        cfg_tri3 = 2'(t3);
        cfg_tri2 = 2'(t2);
        cfg_tri1 = 2'($urandom_range(2));
        offset_select_a = 3'($urandom);
        cfg_pin = 6'($urandom);
        restart();
        ep = 3'(exp_page(t3, t2));
        chk("page_id", ee_exp(ep, 7'h00), page_id);
        chk("ch_div", ee_exp(ep, 7'h09), ch_div[0]);
        chk("invalid", ep == 3'h7, cfg_invalid);
        chk("addr_lsb", (cfg_tri1 == TRI_VDD) ? ADDR_VDD : cfg_tri1,
            i2c_addr_lsb);
        chk("offset_select_a", {cfg_pin[4], offset_select_a},
            {offset_select_a_enable, offset_select_a_offset});
        step(2);
        chk("sync_n", !cfg_pin[0], div_sync);
        cfg_pin[0] = !cfg_pin[0];
        cfg_tri2 = cfg_tri2 ^ 2'h1;
        step(3);
        chk("sync_n", !cfg_pin[0], div_sync);
        chk("latched", ee_exp(ep, 7'h00), page_id);
      end
    end
    end_of_test();
  end
endmodule : test_psc_loader
